// file: design/wrau_consts.svh
// Constants for the working register address unit.
// Assumes an 8-bit register file address space of 256 bytes.
`ifndef WRAU_CONSTS_SVH
`define WRAU_CONSTS_SVH

`define WRAU_FIRST_PTR_ADDR 8'hD6
`define WRAU_SECOND_PTR_ADDR 8'hD7
`define WRAU_FIRST_PTR_RST 8'hC0
`define WRAU_SECOND_PTR_RST 8'hC8
`define WRAU_SLICE_STEP 8'h08
`define WRAU_SLICE_COUNT 32
`define WRAU_WR8_PREFIX 4'hC
`define WRAU_UPPER_BASE 8'hC0
`define WRAU_COMMON_LAST 8'hCF
`define WRAU_SLICE_HI 7
`define WRAU_SLICE_LO 3

`endif

// file: design/wrau_pkg.sv
// Types shared by the working register address unit.
// Assumes the constants header is included by each user.
package wrau_pkg;

    typedef enum logic [1:0] {
        WRAU_PTR_NONE = 2'b00,
        WRAU_PTR_BOTH = 2'b01,
        WRAU_PTR_FIRST = 2'b10,
        WRAU_PTR_SECOND = 2'b11
    } wrau_ptr_cmd_t;

    typedef enum logic [1:0] {
        WRAU_SET_NORMAL = 2'b00,
        WRAU_SET_UPPER1 = 2'b01,
        WRAU_SET_UPPER2 = 2'b10
    } wrau_space_t;

endpackage

// file: design/wrau_slice_mux.sv
// Forms a register address from a 4-bit working register index and two pointers.
// Assumes pointers come from the same clock domain; purely combinational.
`timescale 1ns/1ps
`include "wrau_consts.svh"
module wrau_slice_mux
    import wrau_pkg::*;
(
    input wire logic [3:0] regIndex,
    input wire logic [7:0] firstPtr,
    input wire logic [7:0] secondPtr,
    output logic [7:0] regAddr,
    output logic usesSecond
);
    wire logic [7:0] chosenPtr;

    assign usesSecond = regIndex[3];
    assign chosenPtr = usesSecond ? secondPtr : firstPtr;
    assign regAddr = {chosenPtr[`WRAU_SLICE_HI:`WRAU_SLICE_LO], regIndex[2:0]};
endmodule

// file: design/wrau_pair_align.sv
// Splits a 16-bit register pair address into its even and odd bytes.
// Assumes the caller supplies any address; bit 0 is forced to even.
`timescale 1ns/1ps
module wrau_pair_align
    import wrau_pkg::*;
(
    input wire logic [7:0] pairAddr,
    input wire logic [15:0] pairData,
    output logic [7:0] evenAddr,
    output logic [7:0] oddAddr,
    output logic [7:0] evenByte,
    output logic [7:0] oddByte
);
    assign evenAddr = {pairAddr[7:1], 1'b0};
    assign oddAddr = {pairAddr[7:1], 1'b1};
    assign evenByte = pairData[15:8];
    assign oddByte = pairData[7:0];
endmodule

// file: design/wrau_top.sv
// Working register address unit: slice pointers and operand address forming.
// Assumes the CPU decoder drives operands and write strobes on ref_clk.
//
// Contract
// - Register file seen as 32 slices.
// - Two pointers select two slices together.
// - Block movable anywhere except second upper set.
// - Slice registers share upper five address bits.
// - Reset pointers to C0H and C8H.
// - Pointers live at D6H and D7H.
// - Pointers load by set instructions or loads.
// - Working operands reach only selected slices.
// - Second upper set only indirect or indexed.
// - Direct mode reaches all but second set.
// - Register pair starts at even address.
// - High byte even, low byte odd.
// - Index top bit picks the pointer.
// - Pointer upper five bits form address top.
// - Index low three bits select register.
// - Common area reachable from any page.
// - Prefix 1100B operand acts as 4-bit index.
`timescale 1ns/1ps
`include "wrau_consts.svh"
module wrau_top
    import wrau_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    // Pointer update from set-pointer instructions.
    input wire wrau_ptr_cmd_t ptrCmd,
    input wire logic [7:0] ptrOperand,
    // Ordinary register write port of the datapath.
    input wire logic regWrEn,
    input wire logic [7:0] regWrAddr,
    input wire logic [7:0] regWrData,
    // Ordinary register read of the pointer locations.
    input wire logic [7:0] regRdAddr,
    output logic [7:0] regRdData,
    output logic regRdHit,
    // Operand decode.
    input wire logic isShortOperand,
    input wire logic [7:0] operand,
    input wire wrau_space_t operandSpace,
    input wire logic [7:0] pageSel,
    output logic [7:0] effAddr,
    output logic effWorking,
    output logic effUpper2,
    output logic effIllegal,
    // Register pair layout.
    input wire logic [15:0] pairData,
    output logic [7:0] pairEvenAddr,
    output logic [7:0] pairOddAddr,
    output logic [7:0] pairHighByte,
    output logic [7:0] pairLowByte,
    output logic [7:0] firstSlicePtr,
    output logic [7:0] secondSlicePtr
);
    logic [7:0] first_slice_pointer_ff;
    logic [7:0] second_slice_pointer_ff;
    logic [7:0] nxt_first_slice_pointer;
    logic [7:0] nxt_second_slice_pointer;

    // Decode of writes aimed at either pointer location.
    wire logic wrFirst;
    wire logic wrSecond;
    wire logic cmdFirst;
    wire logic cmdSecond;
    wire logic [7:0] operandPlus8;
    wire logic isWorking;
    wire logic [3:0] workIndex;
    wire logic [7:0] workAddr;
    wire logic upperAddr;
    wire logic commonAddr;
    wire logic upper2Ok;
    wire logic directIllegal;

    function automatic logic hitsUpper(input logic [7:0] addr);
        hitsUpper = (addr >= `WRAU_UPPER_BASE);
    endfunction

    function automatic logic hitsCommon(input logic [7:0] addr);
        hitsCommon = hitsUpper(addr) && (addr <= `WRAU_COMMON_LAST);
    endfunction

    assign wrFirst = regWrEn && (regWrAddr == `WRAU_FIRST_PTR_ADDR);
    assign wrSecond = regWrEn && (regWrAddr == `WRAU_SECOND_PTR_ADDR);
    assign cmdFirst = (ptrCmd == WRAU_PTR_BOTH) || (ptrCmd == WRAU_PTR_FIRST);
    assign cmdSecond = (ptrCmd == WRAU_PTR_BOTH) || (ptrCmd == WRAU_PTR_SECOND);
    assign operandPlus8 = 8'(ptrOperand + `WRAU_SLICE_STEP);

    // The set-pointer instruction wins if both sources fire in one cycle,
    // since the decoder never issues both for one instruction.
    always_comb begin
        nxt_first_slice_pointer = first_slice_pointer_ff;
        nxt_second_slice_pointer = second_slice_pointer_ff;
        if (wrFirst) begin
            nxt_first_slice_pointer = regWrData;
        end
        if (wrSecond) begin
            nxt_second_slice_pointer = regWrData;
        end
        if (cmdFirst) begin
            nxt_first_slice_pointer = ptrOperand;
        end
        if (ptrCmd == WRAU_PTR_BOTH) begin
            nxt_second_slice_pointer = operandPlus8;
        end else if (cmdSecond) begin
            nxt_second_slice_pointer = ptrOperand;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            first_slice_pointer_ff <= `WRAU_FIRST_PTR_RST;
            second_slice_pointer_ff <= `WRAU_SECOND_PTR_RST;
        end else begin
            first_slice_pointer_ff <= nxt_first_slice_pointer;
            second_slice_pointer_ff <= nxt_second_slice_pointer;
        end
    end

    assign firstSlicePtr = first_slice_pointer_ff;
    assign secondSlicePtr = second_slice_pointer_ff;

    // Pointer readback through the ordinary register read path.
    assign regRdHit = (regRdAddr == `WRAU_FIRST_PTR_ADDR) ||
                      (regRdAddr == `WRAU_SECOND_PTR_ADDR);
    assign regRdData = (regRdAddr == `WRAU_FIRST_PTR_ADDR) ? first_slice_pointer_ff :
                       (regRdAddr == `WRAU_SECOND_PTR_ADDR) ? second_slice_pointer_ff :
                       8'h00;

    // A short 4-bit operand or an 8-bit operand with prefix 1100B is working.
    assign isWorking = isShortOperand ||
                       (operand[7:4] == `WRAU_WR8_PREFIX);
    assign workIndex = operand[3:0];

    // Pointers are 8 bits with the slice in the top five, giving 32 slices.
    wrau_slice_mux u_slice_mux (
        .regIndex(workIndex),
        .firstPtr(first_slice_pointer_ff),
        .secondPtr(second_slice_pointer_ff),
        .regAddr(workAddr),
        .usesSecond()
    );

    assign upperAddr = hitsUpper(operand);
    assign commonAddr = hitsCommon(operand);
    // The upper set as a second space is only for indirect and indexed modes.
    assign upper2Ok = (operandSpace == WRAU_SET_UPPER2) && upperAddr;
    // Direct naming of the common area never flags: its 1100B prefix always decodes as a working access.
    assign directIllegal = !isWorking &&
                           ((operandSpace == WRAU_SET_NORMAL) && commonAddr);

    // Working decode ignores pageSel, so the common area is page independent,
    // and the result always lands in the first space, never the second set.
    assign effAddr = isWorking ? workAddr : operand;
    assign effWorking = isWorking;
    assign effUpper2 = !isWorking && upper2Ok;
    assign effIllegal = directIllegal ||
                        (!isWorking && (operandSpace == WRAU_SET_UPPER2) && !upperAddr);

    wrau_pair_align u_pair_align (
        .pairAddr(effAddr),
        .pairData(pairData),
        .evenAddr(pairEvenAddr),
        .oddAddr(pairOddAddr),
        .evenByte(pairHighByte),
        .oddByte(pairLowByte)
    );

    wire logic unusedPage;
    assign unusedPage = ^pageSel;

    property p_reset_values;
        @(posedge ref_clk) !rst_b |=> (first_slice_pointer_ff == `WRAU_FIRST_PTR_RST) &&
            (second_slice_pointer_ff == `WRAU_SECOND_PTR_RST);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset pointers");

    property p_set_both;
        @(posedge ref_clk) disable iff (!rst_b)
            (ptrCmd == WRAU_PTR_BOTH) |=> (first_slice_pointer_ff == $past(ptrOperand)) &&
            (second_slice_pointer_ff == $past(ptrOperand) + 8'h08);
    endproperty
    a_set_both: assert property (p_set_both) else $error("set both wrong");

    property p_set_first_only;
        @(posedge ref_clk) disable iff (!rst_b)
            (ptrCmd == WRAU_PTR_FIRST) && !wrSecond |=> $stable(second_slice_pointer_ff);
    endproperty
    a_set_first_only: assert property (p_set_first_only) else $error("second moved");

    property p_load_write;
        @(posedge ref_clk) disable iff (!rst_b)
            wrSecond && (ptrCmd == WRAU_PTR_NONE) |=>
            (second_slice_pointer_ff == $past(regWrData));
    endproperty
    a_load_write: assert property (p_load_write) else $error("load missed");

    sequence s_write_first;
        wrFirst && (ptrCmd == WRAU_PTR_NONE);
    endsequence
    property p_next_decode;
        @(posedge ref_clk) disable iff (!rst_b)
            s_write_first ##1 (isShortOperand && !operand[3]) |->
            (effAddr[7:3] == $past(regWrData[7:3]));
    endproperty
    a_next_decode: assert property (p_next_decode) else $error("stale pointer");

    property p_work_addr;
        @(posedge ref_clk) disable iff (!rst_b)
            isWorking |-> effAddr == {(operand[3] ? second_slice_pointer_ff[7:3] :
            first_slice_pointer_ff[7:3]), operand[2:0]};
    endproperty
    a_work_addr: assert property (p_work_addr) else $error("bad working address");

    property p_prefix;
        @(posedge ref_clk) disable iff (!rst_b)
            (operand[7:4] == 4'hC) |-> effWorking && !effUpper2;
    endproperty
    a_prefix: assert property (p_prefix) else $error("prefix not working");

    property p_pair;
        @(posedge ref_clk) disable iff (!rst_b)
            (pairOddAddr == pairEvenAddr + 8'h01) && !pairEvenAddr[0] &&
            (pairHighByte == pairData[15:8]);
    endproperty
    a_pair: assert property (p_pair) else $error("pair layout wrong");

    property p_set_first_value;
        @(posedge ref_clk) disable iff (!rst_b)
            (ptrCmd == WRAU_PTR_FIRST) |=> (first_slice_pointer_ff == $past(ptrOperand));
    endproperty
    a_set_first_value: assert property (p_set_first_value) else $error("first not set");

    property p_set_second_value;
        @(posedge ref_clk) disable iff (!rst_b)
            (ptrCmd == WRAU_PTR_SECOND) |=> (second_slice_pointer_ff == $past(ptrOperand));
    endproperty
    a_set_second_value: assert property (p_set_second_value) else $error("second not set");

    property p_set_second_only;
        @(posedge ref_clk) disable iff (!rst_b)
            (ptrCmd == WRAU_PTR_SECOND) && !wrFirst |=> $stable(first_slice_pointer_ff);
    endproperty
    a_set_second_only: assert property (p_set_second_only) else $error("first moved");

    property p_load_first;
        @(posedge ref_clk) disable iff (!rst_b)
            wrFirst && (ptrCmd == WRAU_PTR_NONE) |=> (first_slice_pointer_ff == $past(regWrData));
    endproperty
    a_load_first: assert property (p_load_first) else $error("first load missed");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_b)
            (ptrCmd == WRAU_PTR_NONE) && !wrFirst && !wrSecond |=>
            $stable(first_slice_pointer_ff) && $stable(second_slice_pointer_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("pointer changed while idle");

    property p_readback;
        @(posedge ref_clk) disable iff (!rst_b)
            regRdHit |-> regRdData == (regRdAddr[0] ? second_slice_pointer_ff :
            first_slice_pointer_ff);
    endproperty
    a_readback: assert property (p_readback) else $error("bad pointer readback");

    property p_low_bits;
        @(posedge ref_clk) disable iff (!rst_b)
            isWorking |-> (effAddr[2:0] == operand[2:0]);
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("bad register in slice");

    property p_common_reset;
        @(posedge ref_clk) disable iff (!rst_b)
            isWorking && (first_slice_pointer_ff == `WRAU_FIRST_PTR_RST) &&
            (second_slice_pointer_ff == `WRAU_SECOND_PTR_RST) |->
            (effAddr >= `WRAU_UPPER_BASE) && (effAddr <= `WRAU_COMMON_LAST);
    endproperty
    a_common_reset: assert property (p_common_reset) else $error("left common area");

    property p_working_first_space;
        @(posedge ref_clk) disable iff (!rst_b)
            isWorking |-> !effUpper2 && !effIllegal;
    endproperty
    a_working_first_space: assert property (p_working_first_space) else $error("working in set 2");

    property p_direct_pass;
        @(posedge ref_clk) disable iff (!rst_b)
            !isWorking |-> (effAddr == operand);
    endproperty
    a_direct_pass: assert property (p_direct_pass) else $error("direct address altered");

    property p_upper2_flag;
        @(posedge ref_clk) disable iff (!rst_b)
            !isWorking && (operandSpace == WRAU_SET_UPPER2) && (operand >= `WRAU_UPPER_BASE) |->
            effUpper2 && !effIllegal;
    endproperty
    a_upper2_flag: assert property (p_upper2_flag) else $error("set 2 access lost");

    property p_pair_low;
        @(posedge ref_clk) disable iff (!rst_b)
            (pairLowByte == pairData[7:0]) && (pairEvenAddr[7:1] == effAddr[7:1]);
    endproperty
    a_pair_low: assert property (p_pair_low) else $error("pair low byte wrong");
endmodule

// file: testbench/wrau_cpu_model.sv
// Behavioural model of the CPU decoder side that updates the slice pointers.
// Assumes the bench calls its tasks; requests change only at falling edges.
`timescale 1ns/1ps
module wrau_cpu_model
    import wrau_pkg::*;
(
    input wire logic ref_clk,
    output wrau_ptr_cmd_t ptrCmd,
    output logic [7:0] ptrOperand,
    output logic regWrEn,
    output logic [7:0] regWrAddr,
    output logic [7:0] regWrData
);
    initial begin
        ptrCmd = WRAU_PTR_NONE;
        ptrOperand = 8'h00;
        regWrEn = 1'b0;
        regWrAddr = 8'h00;
        regWrData = 8'h00;
    end

    // Idle fields show the inverse of the last value so a stale read cannot pass.
    // Pointers may be placed in any order, reversed slices included.
    task automatic setPtr(input wrau_ptr_cmd_t cmd, input logic [7:0] val);
        @(negedge ref_clk);
        ptrCmd = cmd;
        ptrOperand = val;
        @(negedge ref_clk);
        ptrCmd = WRAU_PTR_NONE;
        ptrOperand = ~val;
    endtask

    task automatic loadReg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        regWrEn = 1'b1;
        regWrAddr = addr;
        regWrData = data;
        @(negedge ref_clk);
        regWrEn = 1'b0;
        regWrAddr = ~addr;
        regWrData = ~data;
    endtask
endmodule

// file: testbench/working_register_address_unit_tb.sv
// Self-checking bench for the working register address unit.
// Assumes the cpu model drives pointer updates and the bench drives decode inputs.
`timescale 1ns/1ps
`include "wrau_consts.svh"
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin nMismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module working_register_address_unit_tb
    import wrau_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    wrau_ptr_cmd_t ptrCmd;
    logic [7:0] ptrOperand, regWrAddr, regWrData, regRdAddr, regRdData, operand, pageSel;
    logic regWrEn, regRdHit, isShortOperand, effWorking, effUpper2, effIllegal;
    wrau_space_t operandSpace;
    logic [7:0] effAddr, pairEvenAddr, pairOddAddr, pairHighByte, pairLowByte;
    logic [7:0] firstSlicePtr, secondSlicePtr;
    logic [15:0] pairData;
    int nMismatch = 0;
    int checksDone = 0;

    always #2 ref_clk = ~ref_clk;

    wrau_cpu_model cpu_u (.ref_clk(ref_clk), .ptrCmd(ptrCmd), .ptrOperand(ptrOperand),
        .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData));

    wrau_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .ptrCmd(ptrCmd),
        .ptrOperand(ptrOperand), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
        .regWrData(regWrData), .regRdAddr(regRdAddr), .regRdData(regRdData),
        .regRdHit(regRdHit), .isShortOperand(isShortOperand), .operand(operand),
        .operandSpace(operandSpace), .pageSel(pageSel), .effAddr(effAddr),
        .effWorking(effWorking), .effUpper2(effUpper2), .effIllegal(effIllegal),
        .pairData(pairData), .pairEvenAddr(pairEvenAddr), .pairOddAddr(pairOddAddr),
        .pairHighByte(pairHighByte), .pairLowByte(pairLowByte),
        .firstSlicePtr(firstSlicePtr), .secondSlicePtr(secondSlicePtr));

    function automatic logic [7:0] wa(input logic [3:0] i, input logic [7:0] a,
        input logic [7:0] b);
        logic [7:0] p;
        p = i[3] ? b : a;
        return {p[7:3], i[2:0]};
    endfunction

    task automatic dec(input logic s, input logic [7:0] op, input wrau_space_t sp);
        @(negedge ref_clk);
        isShortOperand = s;
        operand = op;
        operandSpace = sp;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
        @(negedge ref_clk);
        regRdAddr = a;
        #1;
        `CHK(regRdData, d)
        `CHK(regRdHit, h)
    endtask

    task automatic conclude();
        $display("counts: checks=%0d mismatches=%0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The whole sequence needs under a hundred cycles; this leaves ample margin.
    initial begin
        repeat (5000) @(posedge ref_clk);
        nMismatch++;
        conclude();
    end

    initial begin
        regRdAddr = 8'h00;
        isShortOperand = 1'b0;
        operand = 8'h00;
        operandSpace = WRAU_SET_NORMAL;
        pageSel = 8'h00;
        pairData = 16'h1234;
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        `CHK(firstSlicePtr, `WRAU_FIRST_PTR_RST)
        `CHK(secondSlicePtr, `WRAU_SECOND_PTR_RST)
        rd(`WRAU_FIRST_PTR_ADDR, 8'hC0, 1'b1);
        rd(`WRAU_SECOND_PTR_ADDR, 8'hC8, 1'b1);
        rd(8'hD8, 8'h00, 1'b0);
        dec(1'b1, 8'h0A, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'hCA)
        dec(1'b0, 8'hC3, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'hC3)
        `CHK(effIllegal, 1'b0)
        $display("test reset done");

        cpu_u.setPtr(WRAU_PTR_BOTH, 8'h70);
        `CHK(firstSlicePtr, 8'h70)
        `CHK(secondSlicePtr, 8'h78)
        for (int i = 0; i < 16; i++) begin
            @(negedge ref_clk);
            pageSel = 8'(i * 17);
            dec(1'b1, 8'(i), WRAU_SET_NORMAL);
            `CHK(effAddr, wa(4'(i), 8'h70, 8'h78))
            `CHK(effWorking, 1'b1)
        end
        cpu_u.setPtr(WRAU_PTR_SECOND, 8'h48);
        `CHK(firstSlicePtr, 8'h70)
        `CHK(secondSlicePtr, 8'h48)
        cpu_u.setPtr(WRAU_PTR_FIRST, 8'hA5);
        `CHK(secondSlicePtr, 8'h48)
        dec(1'b1, 8'h03, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'hA3)
        dec(1'b1, 8'h0E, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'h4E)
        cpu_u.setPtr(WRAU_PTR_BOTH, 8'hF0);
        dec(1'b1, 8'h07, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'hF7)
        dec(1'b1, 8'h0F, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'hFF)
        $display("test set pointers done");

        cpu_u.loadReg(`WRAU_SECOND_PTR_ADDR, 8'hA8);
        `CHK(secondSlicePtr, 8'hA8)
        // The operand stands across the load so the very next decode sees the new pointer.
        dec(1'b1, 8'h02, WRAU_SET_NORMAL);
        cpu_u.loadReg(`WRAU_FIRST_PTR_ADDR, 8'h00);
        `CHK(firstSlicePtr, 8'h00)
        `CHK(effAddr, 8'h02)
        cpu_u.loadReg(8'hD8, 8'h55);
        `CHK(firstSlicePtr, 8'h00)
        `CHK(secondSlicePtr, 8'hA8)
        rd(`WRAU_SECOND_PTR_ADDR, 8'hA8, 1'b1);
        dec(1'b0, 8'hCB, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'hAB)
        `CHK(effWorking, 1'b1)
        dec(1'b0, 8'hC4, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'h04)
        $display("test loads done");

        dec(1'b0, 8'h41, WRAU_SET_NORMAL);
        `CHK(effAddr, 8'h41)
        `CHK(effWorking, 1'b0)
        `CHK(effUpper2, 1'b0)
        `CHK(effIllegal, 1'b0)
        `CHK(pairEvenAddr, 8'h40)
        `CHK(pairOddAddr, 8'h41)
        `CHK(pairHighByte, 8'h12)
        `CHK(pairLowByte, 8'h34)
        dec(1'b0, 8'h41, WRAU_SET_UPPER2);
        `CHK(effIllegal, 1'b1)
        `CHK(effUpper2, 1'b0)
        dec(1'b0, 8'hE5, WRAU_SET_UPPER2);
        `CHK(effUpper2, 1'b1)
        `CHK(effAddr, 8'hE5)
        `CHK(effIllegal, 1'b0)
        dec(1'b0, 8'hE5, WRAU_SET_NORMAL);
        `CHK(effUpper2, 1'b0)
        dec(1'b0, 8'hE5, WRAU_SET_UPPER1);
        `CHK(effUpper2, 1'b0)
        `CHK(effIllegal, 1'b0)
        dec(1'b1, 8'h05, WRAU_SET_UPPER2);
        `CHK(effUpper2, 1'b0)
        `CHK(effAddr, 8'h05)
        $display("test direct and pairs done");

        @(negedge ref_clk);
        rst_b = 1'b0;
        @(negedge ref_clk);
        rst_b = 1'b1;
        `CHK(firstSlicePtr, 8'hC0)
        `CHK(secondSlicePtr, 8'hC8)
        $display("test second reset done");
        conclude();
    end
endmodule
